// [vdbar_map.vh]
// Purpose: Register map, field positions and reset values of the decoder buffer address bank.
// Assumes: the Avalon-MM slave address carries byte addresses, compared directly with these offsets.
// Notes: All offsets are byte addresses on the 32-bit register bus.
`ifndef VDBAR_MAP_VH
`define VDBAR_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define VDBAR_STREAM_INFO_OFF 32'h0090_0018
`define VDBAR_MB_CTRL_OFF 32'h0090_0024
`define VDBAR_DMV_OFF 32'h0090_0028
`define VDBAR_INTRA_DC_OFF 32'h0090_002c
`define VDBAR_STREAM_OFF 32'h0090_0030
`define VDBAR_OUT_PIC_OFF 32'h0090_0034
`define VDBAR_REF0_OFF 32'h0090_0038
`define VDBAR_REF1_OFF 32'h0090_003c
`define VDBAR_REF2_OFF 32'h0090_0040
`define VDBAR_MODE_OFF 32'h0090_0100
`define VDBAR_IRQ_STAT_OFF 32'h0090_0104
`define VDBAR_IRQ_EN_OFF 32'h0090_0108
`define VDBAR_IRQ_CLR_OFF 32'h0090_010c

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define VDBAR_SCP_BIT 31
`define VDBAR_QP_MSB 30
`define VDBAR_QP_LSB 25
`define VDBAR_LEN_MSB 24
`define VDBAR_LEN_LSB 0
`define VDBAR_RLC_BIT 0
`define VDBAR_JPEG_BIT 1
`define VDBAR_FBIT_MSB 7
`define VDBAR_FBIT_LSB 2
`define VDBAR_ALIGN_MASK 32'hffff_fffc
`define VDBAR_IRQ_W 2
`define VDBAR_EV_WB 0
`define VDBAR_EV_ERR 1
`define VDBAR_RESET_VAL 32'h0000_0000

`endif

// [vdbar_regs.v]
// Purpose: Buffer base address and stream setup registers of a hardware video decoder.
// Assumes: Decoder core events come from logic on clock_in.
// Notes: Avalon-MM slave, one wait cycle on every access.
// Notes on behaviour
// - Initial quantizer field gives picture quantizer value at decode start.
// - Start code present bit: 0 no start codes, 1 start codes.
// - Read-write register holds macroblock control base address.
// - Read-write register holds differential motion vector base address.
// - One base register: intra 4x4 mode in H.264, DC in MPEG-4.
// - Run-level enable 1: stream base is run-level data fetch address.
// - Run-level enable 0: stream base is byte start, bit given by offset field.
// - Buffer exhausted or picture incomplete: hardware writes last used byte address.
// - Stream error or slice order event still writes last byte address.
// - Output picture written starting at output picture base address.
// - Three registers hold reference picture 0, 1 and 2 base addresses.
// - Run-level enable selects variable-length stream or run-level input.
// - First bit offset names starting bit within first stream word.
`timescale 1ns/1ps
`include "vdbar_map.vh"

module vdbar_regs (
  input wire clock_in,
  input wire rst_b_in,
  input wire [31:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [3:0] avs_byteenable_in,
  input wire [31:0] avs_writedata_in,
  output reg [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  input wire stream_buffer_exhausted_in,
  input wire picture_complete_flag_in,
  input wire stream_error_in,
  input wire arbitrary_slice_order_in,
  input wire [31:0] last_byte_addr_in,
  output reg [5:0] initial_quantizer_out,
  output reg start_code_present_out,
  output reg [24:0] stream_length_out,
  output reg run_level_input_enable_out,
  output reg jpeg_mode_out,
  output reg [5:0] first_bit_offset_out,
  output reg [31:0] macroblock_ctrl_base_out,
  output reg [31:0] diff_motion_vector_base_out,
  output reg [31:0] intra_mode_dc_base_out,
  output reg [31:0] run_level_base_out,
  output reg [31:0] stream_start_byte_out,
  output reg [31:0] output_picture_base_out,
  output reg [31:0] ref_picture0_base_out,
  output reg [31:0] ref_picture1_base_out,
  output reg [31:0] ref_picture2_base_out,
  output wire irq_out
);

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  reg [31:0] info_q;
  reg [31:0] mode_q;
  reg [31:0] mbc_q;
  reg [31:0] dmv_q;
  reg [31:0] idc_q;
  reg [31:0] strm_q;
  reg [31:0] opic_q;
  reg [31:0] ref0_q;
  reg [31:0] ref1_q;
  reg [31:0] ref2_q;
  reg [1:0] irq_stat_q;
  reg [1:0] irq_en_q;
  reg ack_q;
  wire req;
  wire wr_go;
  wire rd_go;
  wire wb_ev;
  wire err_ev;
  reg [1:0] irq_set;
  reg [31:0] rd_d;
  reg ack_d;

  // --------------------------------------------------------------------------
  // Next values and write strobes
  // --------------------------------------------------------------------------
  reg [31:0] info_d;
  reg [31:0] mode_d;
  reg [31:0] mbc_d;
  reg [31:0] dmv_d;
  reg [31:0] idc_d;
  reg [31:0] strm_d;
  reg [31:0] opic_d;
  reg [31:0] ref0_d;
  reg [31:0] ref1_d;
  reg [31:0] ref2_d;
  reg [1:0] irq_en_d;
  reg [1:0] irq_stat_d;
  wire wr_info;
  wire wr_mode;
  wire wr_mbc;
  wire wr_dmv;
  wire wr_idc;
  wire wr_strm;
  wire wr_opic;
  wire wr_ref0;
  wire wr_ref1;
  wire wr_ref2;
  wire wr_irq_en;
  wire wr_irq_clr;
  wire hw_wb;
  wire [31:0] rl_base_d;
  wire [31:0] byte_start_d;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  function hit;
    input [31:0] a;
    input [31:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // Aligned base registers drop the two low address bits on every write.
  function [31:0] aligned;
    input [31:0] v;
    begin
      aligned = v & `VDBAR_ALIGN_MASK;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Bus handshake
  // --------------------------------------------------------------------------
  // The single wait state registers the decode so read data comes from flops.
  assign req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_q;
  assign wr_go = avs_write_in & ack_q;
  assign rd_go = avs_read_in & ~ack_q;
  // A read is decoded in the wait cycle so its data stands at the accepting edge.

  // Writeback events; the error path also returns the address for debugging.
  assign wb_ev = stream_buffer_exhausted_in | ~picture_complete_flag_in;
  assign err_ev = stream_error_in | arbitrary_slice_order_in;

  always @* begin
    ack_d = req & ~ack_q;
  end

  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  // --------------------------------------------------------------------------
  // Write strobes
  // --------------------------------------------------------------------------
  // One strobe per register keeps the write decode in a single place.
  assign wr_info = wr_go & hit(avs_address_in, `VDBAR_STREAM_INFO_OFF);
  assign wr_mode = wr_go & hit(avs_address_in, `VDBAR_MODE_OFF);
  assign wr_mbc = wr_go & hit(avs_address_in, `VDBAR_MB_CTRL_OFF);
  assign wr_dmv = wr_go & hit(avs_address_in, `VDBAR_DMV_OFF);
  assign wr_idc = wr_go & hit(avs_address_in, `VDBAR_INTRA_DC_OFF);
  assign wr_strm = wr_go & hit(avs_address_in, `VDBAR_STREAM_OFF);
  assign wr_opic = wr_go & hit(avs_address_in, `VDBAR_OUT_PIC_OFF);
  assign wr_ref0 = wr_go & hit(avs_address_in, `VDBAR_REF0_OFF);
  assign wr_ref1 = wr_go & hit(avs_address_in, `VDBAR_REF1_OFF);
  assign wr_ref2 = wr_go & hit(avs_address_in, `VDBAR_REF2_OFF);
  assign wr_irq_en = wr_go & hit(avs_address_in, `VDBAR_IRQ_EN_OFF);
  assign wr_irq_clr = wr_go & hit(avs_address_in, `VDBAR_IRQ_CLR_OFF);
  assign hw_wb = wb_ev | err_ev;

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  always @* begin
    info_d = info_q;
    mode_d = mode_q;
    mbc_d = mbc_q;
    dmv_d = dmv_q;
    idc_d = idc_q;
    opic_d = opic_q;
    ref0_d = ref0_q;
    ref1_d = ref1_q;
    ref2_d = ref2_q;
    irq_en_d = irq_en_q;
    if (wr_info) begin
      info_d = merge(info_q, avs_writedata_in, avs_byteenable_in);
    end else if (wr_mode) begin
      mode_d = merge(mode_q, avs_writedata_in, avs_byteenable_in);
    end else if (wr_mbc) begin
      mbc_d = aligned(merge(mbc_q, avs_writedata_in, avs_byteenable_in));
    end else if (wr_dmv) begin
      dmv_d = merge(dmv_q, avs_writedata_in, avs_byteenable_in);
    end else if (wr_idc) begin
      idc_d = merge(idc_q, avs_writedata_in, avs_byteenable_in);
    end else if (wr_opic) begin
      opic_d = aligned(merge(opic_q, avs_writedata_in, avs_byteenable_in));
    end else if (wr_ref0) begin
      ref0_d = aligned(merge(ref0_q, avs_writedata_in, avs_byteenable_in));
    end else if (wr_ref1) begin
      ref1_d = aligned(merge(ref1_q, avs_writedata_in, avs_byteenable_in));
    end else if (wr_ref2) begin
      ref2_d = aligned(merge(ref2_q, avs_writedata_in, avs_byteenable_in));
    end else if (wr_irq_en) begin
      irq_en_d = avs_writedata_in[1:0];
    end
  end

  // Hardware writeback wins over a software write in the same cycle.
  always @* begin
    strm_d = strm_q;
    if (hw_wb) begin
      strm_d = last_byte_addr_in;
    end else if (wr_strm) begin
      strm_d = merge(strm_q, avs_writedata_in, avs_byteenable_in);
    end
  end

  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      info_q <= `VDBAR_RESET_VAL;
      mode_q <= `VDBAR_RESET_VAL;
      mbc_q <= `VDBAR_RESET_VAL;
      dmv_q <= `VDBAR_RESET_VAL;
      idc_q <= `VDBAR_RESET_VAL;
      strm_q <= `VDBAR_RESET_VAL;
      opic_q <= `VDBAR_RESET_VAL;
      ref0_q <= `VDBAR_RESET_VAL;
      ref1_q <= `VDBAR_RESET_VAL;
      ref2_q <= `VDBAR_RESET_VAL;
      irq_en_q <= 2'b00;
    end else begin
      info_q <= info_d;
      mode_q <= mode_d;
      mbc_q <= mbc_d;
      dmv_q <= dmv_d;
      idc_q <= idc_d;
      strm_q <= strm_d;
      opic_q <= opic_d;
      ref0_q <= ref0_d;
      ref1_q <= ref1_d;
      ref2_q <= ref2_d;
      irq_en_q <= irq_en_d;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status
  // --------------------------------------------------------------------------
  always @* begin
    irq_set = 2'b00;
    irq_set[`VDBAR_EV_WB] = wb_ev;
    irq_set[`VDBAR_EV_ERR] = err_ev;
  end

  // A new event in the clearing cycle survives, so no event is ever lost.
  always @* begin
    irq_stat_d = irq_stat_q | irq_set;
    if (wr_irq_clr) begin
      irq_stat_d = (irq_stat_q & ~avs_writedata_in[1:0]) | irq_set;
    end
  end

  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_stat_q <= 2'b00;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  assign irq_out = |(irq_stat_q & irq_en_q);

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  always @* begin
    rd_d = 32'h0000_0000;
    if (hit(avs_address_in, `VDBAR_STREAM_INFO_OFF)) begin
      rd_d = info_q;
    end else if (hit(avs_address_in, `VDBAR_MODE_OFF)) begin
      rd_d = mode_q;
    end else if (hit(avs_address_in, `VDBAR_MB_CTRL_OFF)) begin
      rd_d = mbc_q;
    end else if (hit(avs_address_in, `VDBAR_DMV_OFF)) begin
      rd_d = dmv_q;
    end else if (hit(avs_address_in, `VDBAR_INTRA_DC_OFF)) begin
      rd_d = idc_q;
    end else if (hit(avs_address_in, `VDBAR_STREAM_OFF)) begin
      rd_d = strm_q;
    end else if (hit(avs_address_in, `VDBAR_OUT_PIC_OFF)) begin
      rd_d = opic_q;
    end else if (hit(avs_address_in, `VDBAR_REF0_OFF)) begin
      rd_d = ref0_q;
    end else if (hit(avs_address_in, `VDBAR_REF1_OFF)) begin
      rd_d = ref1_q;
    end else if (hit(avs_address_in, `VDBAR_REF2_OFF)) begin
      rd_d = ref2_q;
    end else if (hit(avs_address_in, `VDBAR_IRQ_STAT_OFF)) begin
      rd_d = {30'h0000_0000, irq_stat_q};
    end else if (hit(avs_address_in, `VDBAR_IRQ_EN_OFF)) begin
      rd_d = {30'h0000_0000, irq_en_q};
    end
  end

  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (rd_go) begin
      avs_readdata_out <= rd_d;
    end
  end

  // --------------------------------------------------------------------------
  // Decoder facing outputs
  // --------------------------------------------------------------------------
  // The stream register is steered to one of two consumers by the input mode.
  // The returned byte address is not meaningful in JPEG mode; software must not use it.
  assign rl_base_d = mode_q[`VDBAR_RLC_BIT] ? strm_q : 32'h0000_0000;
  assign byte_start_d = mode_q[`VDBAR_RLC_BIT] ? 32'h0000_0000 : strm_q;

  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      initial_quantizer_out <= 6'h00;
      start_code_present_out <= 1'b0;
      stream_length_out <= 25'h000_0000;
      run_level_input_enable_out <= 1'b0;
      jpeg_mode_out <= 1'b0;
      first_bit_offset_out <= 6'h00;
      macroblock_ctrl_base_out <= 32'h0000_0000;
      diff_motion_vector_base_out <= 32'h0000_0000;
      intra_mode_dc_base_out <= 32'h0000_0000;
      run_level_base_out <= 32'h0000_0000;
      stream_start_byte_out <= 32'h0000_0000;
      output_picture_base_out <= 32'h0000_0000;
      ref_picture0_base_out <= 32'h0000_0000;
      ref_picture1_base_out <= 32'h0000_0000;
      ref_picture2_base_out <= 32'h0000_0000;
    end else begin
      initial_quantizer_out <= info_q[`VDBAR_QP_MSB:`VDBAR_QP_LSB];
      start_code_present_out <= info_q[`VDBAR_SCP_BIT];
      stream_length_out <= info_q[`VDBAR_LEN_MSB:`VDBAR_LEN_LSB];
      run_level_input_enable_out <= mode_q[`VDBAR_RLC_BIT];
      jpeg_mode_out <= mode_q[`VDBAR_JPEG_BIT];
      first_bit_offset_out <= mode_q[`VDBAR_FBIT_MSB:`VDBAR_FBIT_LSB];
      macroblock_ctrl_base_out <= mbc_q;
      diff_motion_vector_base_out <= dmv_q;
      intra_mode_dc_base_out <= idc_q;
      run_level_base_out <= rl_base_d;
      stream_start_byte_out <= byte_start_d;
      output_picture_base_out <= opic_q;
      ref_picture0_base_out <= ref0_q;
      ref_picture1_base_out <= ref1_q;
      ref_picture2_base_out <= ref2_q;
    end
  end

endmodule // vdbar_regs

// [vdbar_regs_monitor.sv]
// Purpose: Port checks for the decoder buffer address bank.
// Assumes: One clock domain, reset active low.
// Notes: Bound to vdbar_regs from the testbench top file.
`timescale 1ns/1ps
`include "vdbar_map.vh"
module vdbar_regs_monitor (
  input wire clock_in,
  input wire rst_b_in,
  input wire [31:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [3:0] avs_byteenable_in,
  input wire [31:0] avs_writedata_in,
  input wire avs_waitrequest_out,
  input wire stream_buffer_exhausted_in,
  input wire picture_complete_flag_in,
  input wire stream_error_in,
  input wire arbitrary_slice_order_in,
  input wire [31:0] last_byte_addr_in,
  input wire [5:0] initial_quantizer_out,
  input wire start_code_present_out,
  input wire run_level_input_enable_out,
  input wire [31:0] macroblock_ctrl_base_out,
  input wire [31:0] diff_motion_vector_base_out,
  input wire [31:0] run_level_base_out,
  input wire [31:0] stream_start_byte_out,
  input wire [31:0] output_picture_base_out,
  input wire [31:0] ref_picture0_base_out
);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Full-word writes only, so byte-lane merging cannot blur the expected value.
  wire ev = stream_buffer_exhausted_in | ~picture_complete_flag_in | stream_error_in |
    arbitrary_slice_order_in;
  wire wr_done = avs_write_in & ~avs_waitrequest_out & (avs_byteenable_in == 4'hf);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  wait_one_a: assert property ($rose(avs_read_in | avs_write_in) |->
    avs_waitrequest_out ##1 !avs_waitrequest_out) else $error("wait cycle count wrong");
  reset_zero_a: assert property ($rose(rst_b_in) |-> macroblock_ctrl_base_out == 0 &&
    initial_quantizer_out == 0 && stream_start_byte_out == 0) else $error("reset value");
  info_wr_a: assert property (wr_done && avs_address_in == `VDBAR_STREAM_INFO_OFF |->
    ##2 initial_quantizer_out == $past(avs_writedata_in[30:25], 2) &&
    start_code_present_out == $past(avs_writedata_in[31], 2)) else $error("info field");
  mb_wr_a: assert property (wr_done && avs_address_in == `VDBAR_MB_CTRL_OFF |-> ##2
    macroblock_ctrl_base_out == ($past(avs_writedata_in, 2) & `VDBAR_ALIGN_MASK))
    else $error("macroblock base");
  dmv_wr_a: assert property (wr_done && avs_address_in == `VDBAR_DMV_OFF |-> ##2
    diff_motion_vector_base_out == $past(avs_writedata_in, 2)) else $error("dmv base");
  last_byte_a: assert property (ev && !run_level_input_enable_out |-> ##2
    (run_level_input_enable_out || stream_start_byte_out == $past(last_byte_addr_in, 2)))
    else $error("writeback address");
  vlc_zero_a: assert property (run_level_input_enable_out |->
    stream_start_byte_out == 0) else $error("byte start shown in run-level mode");
  rl_zero_a: assert property (!run_level_input_enable_out |->
    run_level_base_out == 0) else $error("run-level base shown in stream mode");
  low_bits_a: assert property (macroblock_ctrl_base_out[1:0] == 2'h0 &&
    output_picture_base_out[1:0] == 2'h0 && ref_picture0_base_out[1:0] == 2'h0)
    else $error("aligned base low bits set");
  cover property (wr_done && avs_address_in == `VDBAR_MB_CTRL_OFF);
  cover property (ev && !run_level_input_enable_out);
  cover property (run_level_input_enable_out);
endmodule // vdbar_regs_monitor

// [vdbar_regs_tb.sv]
// Purpose: Self-checking bench for the decoder buffer address bank.
// Assumes: Avalon-MM master with one request at a time.
// Notes: Expected values come from the stimulus and the map constants, never from the design.
`timescale 1ns/1ps
`include "vdbar_map.vh"
module vdbar_regs_tb;
  logic clock_in = 0, rst_b_in = 0, avs_read_in = 0, avs_write_in = 0;
  logic [31:0] avs_address_in = 0, avs_writedata_in = 0, last_byte_addr_in = 0;
  logic [3:0] avs_byteenable_in = 4'hf;
  logic stream_buffer_exhausted_in = 0, picture_complete_flag_in = 1;
  logic stream_error_in = 0, arbitrary_slice_order_in = 0;
  wire [31:0] avs_readdata_out, macroblock_ctrl_base_out, diff_motion_vector_base_out;
  wire [31:0] intra_mode_dc_base_out, run_level_base_out, stream_start_byte_out;
  wire [31:0] output_picture_base_out, ref_picture0_base_out, ref_picture1_base_out;
  wire [31:0] ref_picture2_base_out;
  wire avs_waitrequest_out, start_code_present_out, run_level_input_enable_out;
  wire jpeg_mode_out, irq_out;
  wire [5:0] initial_quantizer_out, first_bit_offset_out;
  wire [24:0] stream_length_out;
  int miscompares = 0, checks = 0;
  logic [31:0] q, d, s;
  logic [31:0] offs [8] = '{`VDBAR_MB_CTRL_OFF, `VDBAR_DMV_OFF, `VDBAR_INTRA_DC_OFF,
    `VDBAR_STREAM_OFF, `VDBAR_OUT_PIC_OFF, `VDBAR_REF0_OFF, `VDBAR_REF1_OFF, `VDBAR_REF2_OFF};
  vdbar_regs dut (.*);
  always #5 clock_in = ~clock_in;
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic wrap_up;
    $display("Counts: checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Request is held until waitrequest is sampled low and released at that same edge.
  task automatic bus(bit wr, logic [31:0] a, logic [31:0] v, output logic [31:0] r);
    int n;
    n = 0;
    avs_address_in <= a;
    avs_writedata_in <= v;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do begin
      @(posedge clock_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    r = avs_readdata_out;
    if (n >= 50) begin
      miscompares++;
      wrap_up();
    end else begin
      avs_write_in <= 0;
      avs_read_in <= 0;
      @(posedge clock_in);
    end
  endtask
  function automatic logic [31:0] outv(int i);
    case (i)
      0: return macroblock_ctrl_base_out;
      1: return diff_motion_vector_base_out;
      2: return intra_mode_dc_base_out;
      3: return stream_start_byte_out;
      4: return output_picture_base_out;
      5: return ref_picture0_base_out;
      6: return ref_picture1_base_out;
      default: return ref_picture2_base_out;
    endcase
  endfunction
  function automatic logic [31:0] expv(int i, logic [31:0] v);
    return (i == 0 || i > 3) ? (v & `VDBAR_ALIGN_MASK) : v;
  endfunction
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    void'($urandom(64615));
    repeat (12) @(posedge clock_in);
    rst_b_in <= 1;
    @(posedge clock_in);
    for (int i = 0; i < 8; i++) begin
      bus(0, offs[i], 0, q);
      chk("reset value", q, `VDBAR_RESET_VAL);
    end
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < 8; i++) begin
        d = (r == 0) ? 32'hffff_ffff : $urandom;
        bus(1, offs[i], d, q);
        bus(0, offs[i], 0, q);
        chk("readback", q, expv(i, d));
        chk("base port", outv(i), expv(i, d));
      end
    end
    bus(1, `VDBAR_DMV_OFF, 32'hffff_ffff, q);
    avs_byteenable_in <= 4'h5;
    bus(1, `VDBAR_DMV_OFF, 32'h0000_0000, q);
    avs_byteenable_in <= 4'hf;
    bus(0, `VDBAR_DMV_OFF, 0, q);
    chk("byte lanes", q, 32'hff00_ff00);
    $display("test base registers done");
    for (int k = 0; k < 4; k++) begin
      d = $urandom;
      d[31] = k[0];
      bus(1, `VDBAR_STREAM_INFO_OFF, d, q);
      bus(0, `VDBAR_STREAM_INFO_OFF, 0, q);
      chk("quantizer", initial_quantizer_out, d[30:25]);
      chk("start code", start_code_present_out, d[31]);
      chk("length", stream_length_out, d[24:0]);
    end
    $display("test stream info done");
    for (int k = 1; k >= 0; k--) begin
      d = {24'h00_0000, 6'($urandom), k[0], k[0]};
      s = $urandom;
      bus(1, `VDBAR_MODE_OFF, d, q);
      bus(1, `VDBAR_STREAM_OFF, s, q);
      bus(0, `VDBAR_STREAM_OFF, 0, q);
      chk("stream readback", q, s);
      chk("run-level enable", run_level_input_enable_out, k[0]);
      chk("jpeg mode", jpeg_mode_out, k[0]);
      chk("run-level base", run_level_base_out, k[0] ? s : 32'h0000_0000);
      chk("byte start", stream_start_byte_out, k[0] ? 32'h0000_0000 : s);
      chk("first bit", first_bit_offset_out, d[7:2]);
    end
    $display("test mode select done");
    for (int k = 0; k < 5; k++) begin
      // The last pass runs with interrupts masked to show the status stays sticky.
      bus(1, `VDBAR_IRQ_EN_OFF, (k < 4) ? 32'h0000_0003 : 32'h0000_0000, q);
      d = $urandom;
      last_byte_addr_in <= d;
      stream_buffer_exhausted_in <= (k == 0 || k == 4);
      picture_complete_flag_in <= (k != 1);
      stream_error_in <= (k == 2);
      arbitrary_slice_order_in <= (k == 3);
      @(posedge clock_in);
      stream_buffer_exhausted_in <= 0;
      picture_complete_flag_in <= 1;
      stream_error_in <= 0;
      arbitrary_slice_order_in <= 0;
      @(posedge clock_in);
      bus(0, `VDBAR_STREAM_OFF, 0, q);
      chk("jpeg clear", jpeg_mode_out, 1'b0);
      chk("last byte", q, d);
      bus(0, `VDBAR_IRQ_STAT_OFF, 0, q);
      chk("status", q, (k == 2 || k == 3) ? 32'h0000_0002 : 32'h0000_0001);
      chk("irq level", irq_out, k < 4);
      bus(1, `VDBAR_IRQ_CLR_OFF, 32'h0000_0003, q);
      chk("irq cleared", irq_out, 1'b0);
    end
    $display("test writeback done");
    bus(0, 32'h0090_0020, 0, q);
    chk("unmapped", q, 32'h0000_0000);
    $display("test unmapped done");
    wrap_up();
  end
endmodule // vdbar_regs_tb
bind vdbar_regs vdbar_regs_monitor mon (.*);
